// ===== design/fan_tach_pkg.sv
// Shared constants and types for the fan tachometer counter
package fan_tach_pkg;
	localparam int unsigned ADDR_W             = 10;
	localparam logic [7:0]  IDX_SPEED_ONE      = 8'h59;
	localparam logic [7:0]  IDX_SPEED_TWO      = 8'h5A;
	localparam logic [7:0]  IDX_START_ONE      = 8'h5B;
	localparam logic [7:0]  IDX_START_TWO      = 8'h5C;
	localparam logic [7:0]  IDX_DIVISOR        = 8'h58;
	localparam int unsigned DIV_ONE_LSB        = 4;
	localparam int unsigned DIV_TWO_LSB        = 6;
	localparam logic [1:0]  DIV_RESET          = 2'h2;
	localparam logic [7:0]  SPEED_RESET        = 8'h00;
	localparam logic [7:0]  START_RESET        = 8'h00;
	localparam logic [7:0]  COUNT_MAX          = 8'hFF;
	localparam int unsigned SYNC_STAGES        = 2;

	// Per-channel software settings
	typedef struct packed {
		logic [1:0] div;
		logic [7:0] start;
	} chan_cfg_t;
endpackage

// ===== design/fan_tachometer_counter.sv
// Two-channel fan tachometer counter with an APB register slave
//
// Decided for this implementation: the APB slave port.
module fan_tachometer_counter
	import fan_tach_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              first_cooler_channel,
	input  wire logic              second_cooler_channel
);
	chan_cfg_t        cfg_q [2];
	logic [7:0]       speed_q [2];
	logic [7:0]       cnt_q [2];
	logic [2:0]       presc_q [2];
	logic [1:0]       sync1_q, sync2_q, sync3_q;
	logic [1:0]       pulse_edge;
	logic [1:0]       start_wr;
	logic [1:0]       tick;
	logic             wr_div;
	logic             acc;
	logic [7:0]       idx;
	logic             mapped;
	logic             ro_hit;
	logic [31:0]      rd_d;
	logic [31:0]      prdata_q;
	logic             pready_q;
	logic             pslverr_q;

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Address decode, word index is the byte address over four
	assign idx    = paddr[9:2];
	assign acc    = psel && penable && pready_q;
	assign ro_hit = (idx == IDX_SPEED_ONE) || (idx == IDX_SPEED_TWO);
	assign mapped = ro_hit || (idx == IDX_START_ONE) ||
		(idx == IDX_START_TWO) || (idx == IDX_DIVISOR);
	assign start_wr[0] = acc && pwrite && !pslverr_q &&
		(idx == IDX_START_ONE);
	assign start_wr[1] = acc && pwrite && !pslverr_q &&
		(idx == IDX_START_TWO);
	assign wr_div = acc && pwrite && !pslverr_q && (idx == IDX_DIVISOR);

	// Read mux, unused bits read zero
	always_comb begin
		rd_d = 32'h0000_0000;
		case (idx)
			IDX_SPEED_ONE: rd_d[7:0] = speed_q[0];
			IDX_SPEED_TWO: rd_d[7:0] = speed_q[1];
			IDX_START_ONE: rd_d[7:0] = cfg_q[0].start;
			IDX_START_TWO: rd_d[7:0] = cfg_q[1].start;
			IDX_DIVISOR: begin
				rd_d[DIV_ONE_LSB+:2] = cfg_q[0].div;
				rd_d[DIV_TWO_LSB+:2] = cfg_q[1].div;
			end
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// APB answer: one access cycle, error on unmapped or read-only write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel && !penable;
			pslverr_q <= psel && !penable &&
				(!mapped || (pwrite && ro_hit));
			if (psel && !penable) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
			end
		end
	end

	// Software settings per channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q[0] <= '{div: DIV_RESET, start: START_RESET};
			cfg_q[1] <= '{div: DIV_RESET, start: START_RESET};
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (start_wr[i]) begin
					cfg_q[i].start <= pwdata[7:0];
				end
			end
			if (wr_div) begin
				cfg_q[0].div <= pwdata[DIV_ONE_LSB+:2];
				cfg_q[1].div <= pwdata[DIV_TWO_LSB+:2];
			end
		end
	end

	// Two-stage synchronisers plus an edge-detect stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			sync3_q <= 2'h0;
		end else begin
			sync1_q <= {second_cooler_channel, first_cooler_channel};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign pulse_edge = sync2_q & ~sync3_q;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		// Divided counting tick
		assign tick[c] = (presc_q[c] ==
			3'((4'h1 << cfg_q[c].div) - 4'h1));

		// Prescaler, restarted by a pulse, preload or divisor write;
		// a divisor write must restart it or it runs past the new limit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				presc_q[c] <= 3'h0;
			end else if (start_wr[c] || pulse_edge[c] || tick[c] ||
				wr_div) begin
				presc_q[c] <= 3'h0;
			end else begin
				presc_q[c] <= presc_q[c] + 3'h1;
			end
		end

		// Period counter and latched reading
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q[c]   <= START_RESET;
				speed_q[c] <= SPEED_RESET;
			end else if (start_wr[c]) begin
				// Restart; the next reading may be stale
				cnt_q[c] <= pwdata[7:0];
			end else if (pulse_edge[c]) begin
				speed_q[c] <= cnt_q[c];
				cnt_q[c]   <= cfg_q[c].start;
			end else if (tick[c] && cnt_q[c] != COUNT_MAX) begin
				cnt_q[c] <= cnt_q[c] + 8'h01;
			end
		end

		chk_latch_on_edge: assert property (@(posedge pclk)
			disable iff (!presetn)
			pulse_edge[c] && !start_wr[c] |=>
				speed_q[c] == $past(cnt_q[c]))
			else $error("reading not latched at pulse end");

		chk_reading_holds: assert property (@(posedge pclk)
			disable iff (!presetn)
			!pulse_edge[c] |=> $stable(speed_q[c]))
			else $error("reading changed without a pulse");

		chk_count_step: assert property (@(posedge pclk)
			disable iff (!presetn)
			tick[c] && !pulse_edge[c] && !start_wr[c] &&
				cnt_q[c] != COUNT_MAX |=>
				cnt_q[c] == $past(cnt_q[c]) + 8'h01)
			else $error("count did not advance on tick");

		chk_count_still: assert property (@(posedge pclk)
			disable iff (!presetn)
			!tick[c] && !pulse_edge[c] && !start_wr[c] |=>
				$stable(cnt_q[c]))
			else $error("count moved between divided ticks");

		chk_start_value: assert property (@(posedge pclk)
			disable iff (!presetn)
			pulse_edge[c] && !start_wr[c] |=>
				cnt_q[c] == cfg_q[c].start)
			else $error("count not started from preload");

		chk_write_restart: assert property (@(posedge pclk)
			disable iff (!presetn)
			start_wr[c] |=> cnt_q[c] == cfg_q[c].start &&
				presc_q[c] == 3'h0)
			else $error("preload write did not restart count");

		chk_saturate: assert property (@(posedge pclk)
			disable iff (!presetn)
			cnt_q[c] == COUNT_MAX && !pulse_edge[c] &&
				!start_wr[c] |=> cnt_q[c] == COUNT_MAX)
			else $error("count wrapped past maximum");

		chk_div_range: assert property (@(posedge pclk)
			disable iff (!presetn)
			presc_q[c] != 3'h0 |-> presc_q[c] <=
				3'((4'h1 << cfg_q[c].div) - 4'h1) ||
				$past(wr_div))
			else $error("prescaler beyond divisor");
	end

	chk_channels_apart: assert property (@(posedge pclk)
		disable iff (!presetn)
		start_wr[0] && !pulse_edge[1] && !start_wr[1] |=>
			$stable(speed_q[1]))
		else $error("channel two disturbed by channel one");

	chk_apb_answer: assert property (@(posedge pclk)
		disable iff (!presetn)
		psel && !penable |=> pready_q ##1 !pready_q)
		else $error("answer not one cycle after setup");
endmodule

// ===== verif/fan_pulse_model.sv
// Behavioural tachometer pins of two cooling fans
module fan_pulse_model (
	input  wire logic [15:0] period [2],
	input  wire logic        pclk,
	output logic      [1:0]  pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// One rise each period; a zero period parks the pin low
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic [15:0] cnt_q = 16'h0;
		always_ff @(posedge pclk) begin
			cnt_q <= (cnt_q + 16'h1 >= period[i]) ? 16'h0 : cnt_q + 16'h1;
		end
		assign pins[i] = (period[i] != 16'h0) && (cnt_q < period[i] / 2);
	end
endmodule

// ===== verif/test_fan_tachometer_counter.sv
// Self-checking bench for the fan tachometer counter
module test_fan_tachometer_counter
	import fan_tach_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic [1:0]        pins;
	logic [15:0]       period [2];
	int                miscompares, n_compared, cycles;
	fan_tachometer_counter dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .first_cooler_channel(pins[0]),
		.second_cooler_channel(pins[1]));
	fan_pulse_model fan_u (.period(period), .pclk(pclk), .pins(pins));
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic check(input string what, input logic [31:0] e,
		input logic [31:0] g, input int tol);
		n_compared++;
		if (g !== e && (tol == 0 || (g !== e - 1 && g !== e + 1))) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	// Transfer, then compare read data and error response
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] wd, input logic [31:0] e, input logic ee,
		input int tol);
		logic [31:0] rd;
		logic        err;
		apb(wr, a, wd, rd, err);
		if (!wr) check("prdata", e, rd, tol);
		check("pslverr", {31'h0, ee}, {31'h0, err}, 0);
	endtask
	// Program both channels and let four slowest pulses pass
	task automatic run_fans(input logic [31:0] dv, s1, s2,
		input logic [15:0] p1, p2);
		period[0] <= p1;
		period[1] <= p2;
		xfer(1, 10'h160, dv, 0, 0, 0);
		xfer(1, 10'h16C, s1, 0, 0, 0);
		xfer(1, 10'h170, s2, 0, 0, 0);
		repeat (4 * 200) @(posedge pclk);
		xfer(0, 10'h160, 0, dv, 0, 0);
		xfer(0, 10'h16C, 0, s1, 0, 0);
	endtask
	task automatic test_reset();
		xfer(0, 10'h164, 0, 32'h0, 0, 0);
		xfer(0, 10'h168, 0, 32'h0, 0, 0);
		xfer(0, 10'h16C, 0, 32'h0, 0, 0);
		xfer(0, 10'h170, 0, 32'h0, 0, 0);
		xfer(0, 10'h160, 0, 32'hA0, 0, 0);
		xfer(1, 10'h164, 32'h55, 0, 1, 0);
		xfer(1, 10'h17C, 32'h55, 0, 1, 0);
		xfer(0, 10'h164, 0, 32'h0, 0, 0);
		$display("test reset done");
	endtask
	task automatic test_count();
		run_fans(32'h00, 32'h10, 32'h20, 16'd40, 16'd60);
		xfer(0, 10'h164, 0, 32'h38, 0, 1);
		xfer(0, 10'h168, 0, 32'h5C, 0, 1);
		$display("test count done");
	endtask
	task automatic test_divisor();
		run_fans(32'h70, 32'h10, 32'h20, 16'd80, 16'd60);
		xfer(0, 10'h164, 0, 32'h1A, 0, 1);
		xfer(0, 10'h168, 0, 32'h3E, 0, 1);
		run_fans(32'hA0, 32'h08, 32'h04, 16'd40, 16'd100);
		xfer(0, 10'h164, 0, 32'h12, 0, 1);
		xfer(0, 10'h168, 0, 32'h1D, 0, 1);
		$display("test divisor done");
	endtask
	task automatic test_saturate();
		run_fans(32'h00, 32'hF0, 32'h00, 16'd200, 16'd200);
		xfer(0, 10'h164, 0, 32'hFF, 0, 0);
		xfer(0, 10'h168, 0, 32'hC8, 0, 1);
		period[0] <= 16'h0;
		period[1] <= 16'h0;
		repeat (400) @(posedge pclk);
		xfer(0, 10'h164, 0, 32'hFF, 0, 0);
		xfer(0, 10'h168, 0, 32'hC8, 0, 1);
		$display("test saturate done");
	endtask
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			print_verdict();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		period[0] = 16'h0;
		period[1] = 16'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_count();
		test_divisor();
		test_saturate();
		print_verdict();
	end
endmodule
